// ---- core/bridge_output_scaler.sv ----
// Output scaler, linearizer and excitation calibration with an APB register port.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module bridge_output_scaler
	import scaler_pkg::*;
#(
	parameter int TBL_POINTS      = 25,
	parameter int CFG_TIMEOUT_LIM = CFG_TIMEOUT_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] indicated_value,
	input  wire logic        indicated_valid,
	input  wire logic [15:0] ref_code,
	input  wire logic        ref_valid,
	output logic      [15:0] dac_code,
	output logic             dac_update,
	output logic             current_out_en,
	output logic             voltage_out_en,
	output logic      [5:0]  exc_step_code
);
	localparam int DW = 52;
	localparam int IW = 5;

	// Elaboration checks on parameters the logic cannot serve.
	generate
		if (TBL_POINTS < 2 || TBL_POINTS > 32) begin : g_bad_points
			$error("TBL_POINTS must lie between 2 and 32");
		end
		if (CFG_TIMEOUT_LIM < 2) begin : g_bad_timeout
			$error("CFG_TIMEOUT_LIM must be at least 2");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_SEEK = 3'b001, ST_SCALE = 3'b011,
		ST_VEX = 3'b010, ST_RATIO = 3'b110, ST_STEP = 3'b111
	} fsm_e;

	typedef struct packed {
		logic                          pready;
		logic [31:0]                   prdata;
		logic                          pslverr;
		logic [5:0]                    s_ctrl;
		logic [31:0]                   s_in1;
		logic [31:0]                   s_in2;
		logic [15:0]                   s_out1;
		logic [15:0]                   s_out2;
		logic [3:0]                    s_cnt;
		logic [31:0]                   tmr;
		logic [5:0]                    a_ctrl;
		logic [31:0]                   a_in1;
		logic [31:0]                   a_in2;
		logic [15:0]                   a_out1;
		logic [15:0]                   a_out2;
		cfg_status_e                   cfg_st;
		logic [IW-1:0]                 tidx;
		logic [31:0]                   tin_stage;
		logic [TBL_POINTS-1:0][31:0]   tin;
		logic [TBL_POINTS-1:0][15:0]   tout;
		logic [IW:0]                   tcnt;
		logic                          cal_en;
		logic                          cal_req;
		logic                          cal_max;
		logic                          meas_req;
		logic                          meas_done;
		logic [5:0]                    step_code;
		logic [15:0]                   meter;
		logic [15:0]                   exc_min;
		logic [15:0]                   exc_max;
		logic [31:0]                   ratio;
		logic [23:0]                   step_q8;
		logic [15:0]                   vex;
		logic [15:0]                   meas;
		logic [15:0]                   nominal;
		logic [31:0]                   x;
		logic                          x_pend;
		logic [15:0]                   ref_mv;
		logic                          ref_pend;
		fsm_e                          st;
		logic [IW-1:0]                 seg;
		logic [15:0]                   b0;
		logic                          neg;
		logic                          div_go;
		logic [DW-1:0]                 div_num;
		logic [DW-1:0]                 div_den;
		logic [15:0]                   dac_code;
		logic                          dac_upd;
		logic                          cur_en;
		logic                          volt_en;
	} state_s;

	state_s s, next_s;
	logic                 div_done;
	logic [DW-1:0]        quot;
	logic [15:0]          code_lo;
	logic [15:0]          code_hi;
	logic                 cur_on;
	logic                 volt_on;
	logic                 wr;
	logic [31:0]          rdv;
	logic                 mapped;
	logic [26:0]          refp;
	logic [31:0]          a0;
	logic [31:0]          a1;
	logic [15:0]          b1;
	logic signed [32:0]   dx;
	logic signed [32:0]   da;
	logic signed [16:0]   dy;
	logic signed [49:0]   prod;
	logic [16:0]          qs;
	logic signed [18:0]   res;
	logic [15:0]          lo_max;
	logic [15:0]          span;
	logic [15:0]          step_mv;

	seq_div #(.DW(DW)) u_div (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.start    (s.div_go),
		.dividend (s.div_num),
		.divisor  (s.div_den),
		.done     (div_done),
		.quotient (quot)
	);

	range_map u_range (
		.cur_range  (s.a_ctrl[F_CUR +: 2]),
		.volt_range (s.a_ctrl[F_VOLT +: 3]),
		.code_lo    (code_lo),
		.code_hi    (code_hi),
		.cur_on     (cur_on),
		.volt_on    (volt_on)
	);

	// Segment endpoints come from the table or from the committed endpoints.
	always_comb begin
		if (s.a_ctrl[F_LIN]) begin
			a0 = s.tin[s.seg];
			a1 = s.tin[s.seg + IW'(1)];
			b1 = s.tout[s.seg + IW'(1)];
		end else begin
			a0 = s.a_in1;
			a1 = s.a_in2;
			b1 = s.a_out2;
		end
		dx   = $signed({s.x[31], s.x}) - $signed({a0[31], a0});
		da   = $signed({a1[31], a1}) - $signed({a0[31], a0});
		dy   = $signed({1'b0, b1}) - $signed({1'b0, s.a_ctrl[F_LIN] ? s.tout[s.seg] : s.a_out1});
		prod = dx * dy;
		qs   = (|quot[DW-1:17]) ? 17'h1FFFF : quot[16:0];
		res  = s.neg ? $signed({3'b000, s.b0}) - $signed({2'b00, qs})
			: $signed({3'b000, s.b0}) + $signed({2'b00, qs});
		refp = ref_code * 27'(FIXED_REF_MV);
		step_mv = s.step_q8[23:8];
	end

	// Register read mux; unmapped or misaligned addresses answer with an error.
	always_comb begin
		mapped = (paddr[1:0] == 2'b00) && (paddr <= A_OUT_CODE);
		case (paddr)
			A_CTRL:     rdv = {26'h0, s.s_ctrl};
			A_IN_EP1:   rdv = s.s_in1;
			A_IN_EP2:   rdv = s.s_in2;
			A_OUT_EP1:  rdv = {16'h0, s.s_out1};
			A_OUT_EP2:  rdv = {16'h0, s.s_out2};
			A_COMMIT:   rdv = {28'h0, s.s_cnt};
			A_CFG_STAT: rdv = {30'h0, s.cfg_st};
			A_TBL_IDX:  rdv = {27'h0, s.tidx};
			A_TBL_IN:   rdv = s.tin_stage;
			A_TBL_CNT:  rdv = {26'h0, s.tcnt};
			A_EXC_CMD:  rdv = {24'h0, s.step_code, s.meas_done, s.cal_en};
			A_METER:    rdv = {16'h0, s.meter};
			A_EXC_MIN:  rdv = {16'h0, s.exc_min};
			A_EXC_MAX:  rdv = {16'h0, s.exc_max};
			A_RATIO:    rdv = s.ratio;
			A_STEP:     rdv = {8'h0, s.step_q8};
			A_MEAS:     rdv = {16'h0, s.meas};
			A_NOMINAL:  rdv = {16'h0, s.nominal};
			A_OUT_CODE: rdv = {16'h0, s.dac_code};
			default:    rdv = 32'h0;
		endcase
	end

	// Bus slave, configuration transfer, table load, commands and datapath sequencing.
	always_comb begin
		next_s = s;
		next_s.div_go  = 1'b0;
		next_s.dac_upd = 1'b0;
		lo_max = s.exc_min;
		span   = 16'h0;
		wr = psel && penable && pwrite && s.pready;
		// Answer one cycle after setup: pready rises in the access phase.
		next_s.pready  = psel && !penable;
		next_s.pslverr = psel && !penable && !mapped;
		next_s.prdata  = (psel && !penable && !pwrite) ? rdv : 32'h0;

		// Staged configuration is discarded if the commit never arrives.
		if (s.s_cnt != 4'h0) begin
			next_s.tmr = s.tmr + 32'h1;
			if (s.tmr == 32'(CFG_TIMEOUT_LIM - 1)) begin
				next_s.cfg_st = CFG_TIMEOUT;
				next_s.s_cnt  = 4'h0;
				next_s.tmr    = 32'h0;
			end
		end

		if (wr) begin
			if (paddr inside {A_CTRL, A_IN_EP1, A_IN_EP2, A_OUT_EP1, A_OUT_EP2}) begin
				next_s.s_cnt = (s.s_cnt == 4'hF) ? s.s_cnt : s.s_cnt + 4'h1;
			end
			case (paddr)
				A_CTRL:    next_s.s_ctrl = pwdata[5:0];
				A_IN_EP1:  next_s.s_in1 = pwdata;
				A_IN_EP2:  next_s.s_in2 = pwdata;
				A_OUT_EP1: next_s.s_out1 = pwdata[15:0];
				A_OUT_EP2: next_s.s_out2 = pwdata[15:0];
				A_COMMIT: begin
					// A word count mismatch or bad range leaves the old setup running.
					if (pwdata[3:0] == s.s_cnt && s.s_cnt != 4'h0
						&& s.s_ctrl[F_CUR +: 2] <= CUR_4_20
						&& s.s_ctrl[F_VOLT +: 3] <= VOLT_0_5) begin
						next_s.a_ctrl = s.s_ctrl;
						next_s.a_in1  = s.s_in1;
						next_s.a_in2  = s.s_in2;
						next_s.a_out1 = s.s_out1;
						next_s.a_out2 = s.s_out2;
						next_s.cfg_st = CFG_OK;
					end else begin
						next_s.cfg_st = CFG_XFER_ERR;
					end
					next_s.s_cnt = 4'h0;
					next_s.tmr   = 32'h0;
				end
				A_TBL_IDX: next_s.tidx = pwdata[IW-1:0];
				A_TBL_IN:  next_s.tin_stage = pwdata;
				A_TBL_OUT: begin
					if (32'(s.tidx) < 32'(TBL_POINTS)) begin
						next_s.tin[s.tidx]  = s.tin_stage;
						next_s.tout[s.tidx] = pwdata[15:0];
						next_s.tidx = s.tidx + IW'(1);
					end
				end
				A_TBL_CNT: begin
					if (pwdata <= 32'(TBL_POINTS)) begin
						next_s.tcnt = pwdata[IW:0];
					end
				end
				A_EXC_CMD: begin
					case (pwdata[2:0])
						CMD_INSTR:   next_s.cal_en = 1'b1;
						CMD_SET_MIN: if (s.cal_en) next_s.step_code = 6'h0;
						CMD_SET_MAX: if (s.cal_en) next_s.step_code = STEP_CODE_MAX;
						CMD_CAL_MIN, CMD_CAL_MAX: begin
							if (s.cal_en) begin
								next_s.cal_req = 1'b1;
								next_s.cal_max = pwdata[0];
							end
						end
						CMD_MEASURE: begin
							next_s.meas_req  = 1'b1;
							next_s.meas_done = 1'b0;
						end
						CMD_EXIT: next_s.cal_en = 1'b0;
						default:  next_s.cal_en = s.cal_en;
					endcase
				end
				A_METER:   next_s.meter = pwdata[15:0];
				A_NOMINAL: next_s.nominal = pwdata[15:0];
				default:   next_s.meter = s.meter;
			endcase
		end

		next_s.cur_en  = cur_on;
		next_s.volt_en = volt_on;

		// Calibration goes first so a stored meter value is never paired with a stale reference.
		case (s.st)
			ST_IDLE: begin
				if (s.cal_req) begin
					next_s.cal_req = 1'b0;
					next_s.div_num = {20'h0, s.ref_mv, 16'h0};
					next_s.div_den = {36'h0, s.meter};
					next_s.div_go  = 1'b1;
					next_s.st      = ST_RATIO;
				end else if (s.ref_pend) begin
					next_s.ref_pend = 1'b0;
					next_s.div_num  = {20'h0, s.ref_mv, 16'h0};
					next_s.div_den  = {20'h0, s.ratio};
					next_s.div_go   = 1'b1;
					next_s.st       = ST_VEX;
				end else if (s.x_pend && (cur_on || volt_on)) begin
					next_s.x_pend = 1'b0;
					next_s.seg    = '0;
					if (!s.a_ctrl[F_LIN] || s.tcnt >= (IW + 1)'(2)) begin
						next_s.st = ST_SEEK;
					end
				end
			end
			ST_SEEK: begin
				// Walk to the pair of points that brackets the value, one point per clock.
				if (s.a_ctrl[F_LIN] && (IW + 1)'(s.seg) + (IW + 1)'(2) < s.tcnt
					&& $signed(s.x) >= $signed(a1)) begin
					next_s.seg = s.seg + IW'(1);
				end else begin
					next_s.b0      = s.a_ctrl[F_LIN] ? s.tout[s.seg] : s.a_out1;
					next_s.neg     = prod[49] ^ da[32];
					next_s.div_num = {2'b00, prod[49] ? 50'(-prod) : 50'(prod)};
					next_s.div_den = {19'h0, da[32] ? 33'(-da) : 33'(da)};
					next_s.div_go  = 1'b1;
					next_s.st      = ST_SCALE;
				end
			end
			ST_SCALE: begin
				if (div_done) begin
					// Clamping keeps every range inside its slice of the converter code.
					if (res < $signed({3'b000, code_lo})) begin
						next_s.dac_code = code_lo;
					end else if (res > $signed({3'b000, code_hi})) begin
						next_s.dac_code = code_hi;
					end else begin
						next_s.dac_code = res[15:0];
					end
					next_s.dac_upd = 1'b1;
					next_s.st      = ST_IDLE;
				end
			end
			ST_VEX: begin
				if (div_done) begin
					next_s.vex = (|quot[DW-1:16]) ? 16'hFFFF : quot[15:0];
					if (s.meas_req) begin
						next_s.meas      = (|quot[DW-1:16]) ? 16'hFFFF : quot[15:0];
						next_s.meas_req  = 1'b0;
						next_s.meas_done = 1'b1;
					end
					// Servo only outside calibration, where the step code must stay put.
					if (!s.cal_en) begin
						if (quot < DW'(s.nominal - step_mv) && s.step_code != STEP_CODE_MAX) begin
							next_s.step_code = s.step_code + 6'h1;
						end else if (quot > DW'(s.nominal + step_mv) && s.step_code != 6'h0) begin
							next_s.step_code = s.step_code - 6'h1;
						end
					end
					next_s.st = ST_IDLE;
				end
			end
			ST_RATIO: begin
				if (div_done) begin
					next_s.ratio = quot[31:0];
					if (s.cal_max) begin
						next_s.exc_max = s.meter;
					end else begin
						next_s.exc_min = s.meter;
						lo_max = s.meter;
					end
					span = s.cal_max ? s.meter : s.exc_max;
					span = (span > lo_max) ? span - lo_max : 16'h0;
					next_s.div_num = {28'h0, span, 8'h0};
					next_s.div_den = DW'(STEP_DIV);
					next_s.div_go  = 1'b1;
					next_s.st      = ST_STEP;
				end
			end
			ST_STEP: begin
				if (div_done) begin
					next_s.step_q8 = quot[23:0];
					next_s.st      = ST_IDLE;
				end
			end
			default: next_s.st = ST_IDLE;
		endcase

		// Samples are taken after the sequencer, so a new arrival beats the consume of the old one.
		if (indicated_valid) begin
			next_s.x      = indicated_value;
			next_s.x_pend = 1'b1;
		end
		if (ref_valid) begin
			next_s.ref_mv   = {5'h0, refp[26:16]};
			next_s.ref_pend = 1'b1;
		end
	end

	// Single state register; constants only under reset.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s           <= '0;
			s.cfg_st    <= CFG_OK;
			s.st        <= ST_IDLE;
			s.ratio     <= RATIO_RST;
			s.exc_min   <= EXC_MIN_RST;
			s.exc_max   <= EXC_MAX_RST;
			s.step_q8   <= STEP_RST;
			s.nominal   <= NOMINAL_RST;
		end else begin
			s <= next_s;
		end
	end

	assign prdata         = s.prdata;
	assign pready         = s.pready;
	assign pslverr        = s.pslverr;
	assign dac_code       = s.dac_code;
	assign dac_update     = s.dac_upd;
	assign current_out_en = s.cur_en;
	assign voltage_out_en = s.volt_en;
	assign exc_step_code  = s.step_code;
endmodule

// ---- core/scaler_pkg.sv ----
// Shared constants, register map and encodings for the bridge output scaler.
package scaler_pkg;
	// Clock rate and the configuration transfer timeout.
	localparam int CLK_KHZ         = 40000;
	localparam int CFG_TIMEOUT_MS  = 100;
	localparam int CFG_TIMEOUT_CYC = CFG_TIMEOUT_MS * CLK_KHZ;

	// Register byte offsets on the APB port.
	localparam logic [7:0] A_CTRL     = 8'h00;
	localparam logic [7:0] A_IN_EP1   = 8'h04;
	localparam logic [7:0] A_IN_EP2   = 8'h08;
	localparam logic [7:0] A_OUT_EP1  = 8'h0C;
	localparam logic [7:0] A_OUT_EP2  = 8'h10;
	localparam logic [7:0] A_COMMIT   = 8'h14;
	localparam logic [7:0] A_CFG_STAT = 8'h18;
	localparam logic [7:0] A_TBL_IDX  = 8'h1C;
	localparam logic [7:0] A_TBL_IN   = 8'h20;
	localparam logic [7:0] A_TBL_OUT  = 8'h24;
	localparam logic [7:0] A_TBL_CNT  = 8'h28;
	localparam logic [7:0] A_EXC_CMD  = 8'h2C;
	localparam logic [7:0] A_METER    = 8'h30;
	localparam logic [7:0] A_EXC_MIN  = 8'h34;
	localparam logic [7:0] A_EXC_MAX  = 8'h38;
	localparam logic [7:0] A_RATIO    = 8'h3C;
	localparam logic [7:0] A_STEP     = 8'h40;
	localparam logic [7:0] A_MEAS     = 8'h44;
	localparam logic [7:0] A_NOMINAL  = 8'h48;
	localparam logic [7:0] A_OUT_CODE = 8'h4C;

	// Control word field positions.
	localparam int F_LIN  = 0;
	localparam int F_CUR  = 1;
	localparam int F_VOLT = 3;

	// Output range selector encodings.
	localparam logic [1:0] CUR_OFF   = 2'h0;
	localparam logic [1:0] CUR_0_20  = 2'h1;
	localparam logic [1:0] CUR_4_20  = 2'h2;
	localparam logic [2:0] VOLT_OFF  = 3'h0;
	localparam logic [2:0] VOLT_PM10 = 3'h1;
	localparam logic [2:0] VOLT_PM5  = 3'h2;
	localparam logic [2:0] VOLT_0_10 = 3'h3;
	localparam logic [2:0] VOLT_0_5  = 3'h4;

	// Converter codes: voltage spans -10..+10 V, current spans 0..24 mA.
	localparam logic [15:0] CODE_MIN    = 16'h0000;
	localparam logic [15:0] CODE_MAX    = 16'hFFFF;
	localparam logic [15:0] CODE_MID    = 16'h8000;
	localparam logic [15:0] CODE_PM5_LO = 16'h4000;
	localparam logic [15:0] CODE_PM5_HI = 16'hBFFF;
	localparam logic [15:0] CODE_4MA    = 16'h2AAA;
	localparam logic [15:0] CODE_20MA   = 16'hD554;

	// Excitation calibration constants and reset values (millivolts, Q16 ratio).
	localparam logic [10:0] FIXED_REF_MV  = 11'h708;
	localparam logic [5:0]  STEP_DIV      = 6'h3F;
	localparam logic [5:0]  STEP_CODE_MAX = 6'h3F;
	localparam logic [31:0] RATIO_RST     = 32'h0000_22F9;
	localparam logic [15:0] EXC_MIN_RST   = 16'h0FA0;
	localparam logic [15:0] EXC_MAX_RST   = 16'h2AF8;
	localparam logic [23:0] STEP_RST      = 24'h006F1C;
	localparam logic [15:0] NOMINAL_RST   = 16'h2710;

	typedef enum logic [1:0] {CFG_OK = 2'h0, CFG_XFER_ERR = 2'h1, CFG_TIMEOUT = 2'h2} cfg_status_e;
	typedef enum logic [2:0] {
		CMD_NONE = 3'h0, CMD_INSTR = 3'h1, CMD_SET_MIN = 3'h2, CMD_SET_MAX = 3'h3,
		CMD_CAL_MIN = 3'h4, CMD_CAL_MAX = 3'h5, CMD_MEASURE = 3'h6, CMD_EXIT = 3'h7
	} exc_cmd_e;
endpackage

// ---- core/range_map.sv ----
// Output range selector: converter code limits for the chosen range.
`timescale 1ns/10ps
module range_map
	import scaler_pkg::*;
(
	input  wire logic [1:0]  cur_range,
	input  wire logic [2:0]  volt_range,
	output logic      [15:0] code_lo,
	output logic      [15:0] code_hi,
	output logic             cur_on,
	output logic             volt_on
);
	// Current wins when both are selected, since only one load may be wired.
	always_comb begin
		cur_on  = (cur_range == CUR_0_20) || (cur_range == CUR_4_20);
		volt_on = !cur_on && (volt_range >= VOLT_PM10) && (volt_range <= VOLT_0_5);
		code_lo = CODE_MIN;
		code_hi = CODE_MAX;
		if (cur_on) begin
			code_lo = (cur_range == CUR_4_20) ? CODE_4MA : CODE_MIN;
			code_hi = CODE_20MA;
		end else begin
			case (volt_range)
				VOLT_PM5: begin
					code_lo = CODE_PM5_LO;
					code_hi = CODE_PM5_HI;
				end
				VOLT_0_10: code_lo = CODE_MID;
				VOLT_0_5: begin
					code_lo = CODE_MID;
					code_hi = CODE_PM5_HI;
				end
				default: code_lo = CODE_MIN;
			endcase
		end
	end
endmodule

// ---- core/seq_div.sv ----
// Unsigned restoring divider, one quotient bit per clock.
`timescale 1ns/10ps
module seq_div #(
	parameter int DW = 52
) (
	input  wire logic          core_clk,
	input  wire logic          rst_n,
	input  wire logic          start,
	input  wire logic [DW-1:0] dividend,
	input  wire logic [DW-1:0] divisor,
	output logic               done,
	output logic      [DW-1:0] quotient
);
	localparam int CW = $clog2(DW + 1);

	// The shift paths slice q[DW-2:0], so narrower words cannot be served.
	generate
		if (DW < 2) begin : g_bad_width
			$error("DW must be at least 2");
		end
	endgenerate
	typedef struct packed {
		logic          busy;
		logic          done;
		logic [CW-1:0] cnt;
		logic [DW:0]   r;
		logic [DW-1:0] q;
		logic [DW-1:0] d;
	} div_s;
	div_s s, next_s;
	logic [DW:0] t;

	// A zero divisor yields all ones, which callers treat as saturation.
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		t = {s.r[DW-1:0], s.q[DW-1]};
		if (start) begin
			next_s.busy = 1'b1;
			next_s.cnt  = CW'(DW);
			next_s.r    = '0;
			next_s.q    = dividend;
			next_s.d    = divisor;
		end else if (s.busy) begin
			if (t >= {1'b0, s.d}) begin
				next_s.r = t - {1'b0, s.d};
				next_s.q = {s.q[DW-2:0], 1'b1};
			end else begin
				next_s.r = t;
				next_s.q = {s.q[DW-2:0], 1'b0};
			end
			next_s.cnt = s.cnt - CW'(1);
			if (s.cnt == CW'(1)) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign done     = s.done;
	assign quotient = s.q;
endmodule

// ---- core/README_unused.sv ----
// Intentionally empty.

// ---- testbench/cfg_host.sv ----
// Host-side APB master model that issues configuration transfers.
`timescale 1ns/10ps
module cfg_host (
	input  wire logic        core_clk,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic [31:0] prdata,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [7:0]  paddr,
	output logic      [31:0] pwdata
);
	logic [31:0] rdata;
	logic        err;
	// Idle bus at time zero.
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
	end
	// One transfer; the wait for pready has no assumed length.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do @(posedge core_clk); while (pready !== 1'h1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Released lines show the inverse so a stale value is never reused.
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule

// ---- testbench/bridge_output_scaler_assertions.sv ----
// Port checker for the bridge output scaler.
`timescale 1ns/10ps
module bridge_output_scaler_assertions
	import scaler_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [15:0] dac_code,
	input wire logic        dac_update,
	input wire logic        current_out_en,
	input wire logic        voltage_out_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	chk_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	chk_ready_single: assert property (pready |-> ##1 !pready)
		else $error("answer longer than one cycle");
	chk_err_unmapped: assert property (psel && !penable && (paddr > A_OUT_CODE ||
		paddr[1:0] != 2'h0) |=> pslverr && pready) else $error("unmapped not refused");
	chk_quiet_data: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	chk_single_output: assert property (!(current_out_en && voltage_out_en))
		else $error("both outputs enabled");
	chk_update_pulse: assert property (dac_update |=> !dac_update)
		else $error("update longer than one cycle");
	chk_code_holds: assert property (!dac_update |-> $stable(dac_code))
		else $error("code moved without update");
	chk_enabled_update: assert property (dac_update |-> current_out_en || voltage_out_en)
		else $error("update while disabled");
endmodule
bind bridge_output_scaler bridge_output_scaler_assertions u_chk (.core_clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dac_code, .dac_update,
	.current_out_en, .voltage_out_en);

// ---- testbench/test_bridge_output_scaler.sv ----
// Self-checking bench for the bridge output scaler.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t got %h want %h", $time, (a), (b)); end end
module test_bridge_output_scaler
	import scaler_pkg::*;
();
	logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        indicated_valid, ref_valid, dac_update, current_out_en, voltage_out_en;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, indicated_value;
	logic [15:0] ref_code, dac_code;
	logic [5:0]  exc_step_code;
	int          errors, samples_checked, seed, v, c, m;
	logic [7:0]  ra [6] = '{A_CFG_STAT, A_RATIO, A_EXC_MIN, A_EXC_MAX, A_STEP, A_NOMINAL};
	logic [31:0] rv [6] = '{32'h0, RATIO_RST, 32'(EXC_MIN_RST), 32'(EXC_MAX_RST),
		32'(STEP_RST), 32'(NOMINAL_RST)};
	logic [31:0] tbo [3] = '{32'h1000, 32'h3000, 32'h2000};
	// The short timeout keeps the abandoned-transfer case brief.
	bridge_output_scaler #(.CFG_TIMEOUT_LIM(50)) DUT (.core_clk, .rst_n, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .indicated_value,
		.indicated_valid, .ref_code, .ref_valid, .dac_code, .dac_update, .current_out_en,
		.voltage_out_en, .exc_step_code);
	cfg_host h (.core_clk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
		.pwdata);
	// A 25 ns clock.
	initial core_clk = 1'h0;
	always #12.5 core_clk = ~core_clk;
	function automatic logic [15:0] exp_ep(input int i1, i2, o1, o2, x);
		return 16'(o1 + (x - i1) * (o2 - o1) / (i2 - i1));
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		h.xfer(1'h1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		h.xfer(1'h0, a, 32'h0);
	endtask
	// Stage all five words, commit them and confirm the status.
	task automatic cfg(input logic [31:0] ct, i1, i2, o1, o2);
		wr(A_CTRL, ct);
		wr(A_IN_EP1, i1);
		wr(A_IN_EP2, i2);
		wr(A_OUT_EP1, o1);
		wr(A_OUT_EP2, o2);
		wr(A_COMMIT, 32'h5);
		rd(A_CFG_STAT);
		`CHK(h.rdata, 32'(CFG_OK))
	endtask
	// One reference and one indicated sample, then a bounded wait for the output.
	task automatic samp(input int x);
		int k;
		@(posedge core_clk);
		indicated_value <= 32'(x);
		indicated_valid <= 1'h1;
		ref_code <= 16'($random(seed));
		ref_valid <= 1'h1;
		@(posedge core_clk);
		indicated_valid <= 1'h0;
		ref_valid <= 1'h0;
		for (k = 0; k < 400 && dac_update !== 1'h1; k++) @(posedge core_clk);
		// An output that never arrives counts as a mismatch of its own.
		if (k == 400) errors++;
		@(posedge core_clk);
	endtask
	task automatic give_verdict();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// A hang counts as a mismatch.
	initial begin
		#1500000;
		errors++;
		give_verdict();
	end
	// Main sequence.
	initial begin
		seed = 85035;
		errors = 0;
		samples_checked = 0;
		rst_n = 1'h0;
		indicated_value = 32'h0;
		indicated_valid = 1'h0;
		ref_code = 16'h0;
		ref_valid = 1'h0;
		repeat (6) @(posedge core_clk);
		rst_n <= 1'h1;
		foreach (ra[i]) begin
			rd(ra[i]);
			`CHK(h.rdata, rv[i])
		end
		rd(8'h50);
		`CHK(h.err, 1'h1)
		// Every range code; current wins when both are chosen.
		for (c = 0; c < 3; c++) begin
			for (m = 0; m < 5; m++) begin
				cfg(32'((c << F_CUR) | (m << F_VOLT)), 0, 1024, 32'h2000, 32'h6000);
				`CHK(current_out_en, c != 0)
				`CHK(voltage_out_en, c == 0 && m != 0)
			end
		end
		// Forward then reverse-acting endpoints, ends of the span first.
		for (c = 0; c < 2; c++) begin
			cfg(32'(VOLT_PM10) << F_VOLT, c * 1024, 1024 - c * 1024, 32'h2000, 32'h6000);
			for (m = 0; m < 6; m++) begin
				v = m == 0 ? 0 : m == 1 ? 1024 : $unsigned($random(seed)) % 1025;
				samp(v);
				`CHK(dac_code, exp_ep(c * 1024, 1024 - c * 1024, 'h2000, 'h6000, v))
			end
		end
		// A miscounted commit is refused and the old setup stays.
		wr(A_CTRL, 32'h0);
		wr(A_COMMIT, 32'h3);
		rd(A_CFG_STAT);
		`CHK(h.rdata, 32'(CFG_XFER_ERR))
		`CHK(voltage_out_en, 1'h1)
		wr(A_CTRL, 32'h0);
		repeat (60) @(posedge core_clk);
		rd(A_CFG_STAT);
		`CHK(h.rdata, 32'(CFG_TIMEOUT))
		// Three-point table, loaded apart from the commit.
		wr(A_TBL_IDX, 32'h0);
		for (m = 0; m < 3; m++) begin
			wr(A_TBL_IN, 32'(m * 100));
			wr(A_TBL_OUT, tbo[m]);
		end
		wr(A_TBL_CNT, 32'h3);
		cfg(32'(1 | (VOLT_PM10 << F_VOLT)), 0, 1024, 32'h2000, 32'h6000);
		rd(A_TBL_CNT);
		`CHK(h.rdata, 32'h3)
		samp(50);
		`CHK(dac_code, 16'h2000)
		samp(150);
		`CHK(dac_code, 16'h2800)
		cfg(32'(1 | (VOLT_0_10 << F_VOLT)), 0, 1024, 32'h2000, 32'h6000);
		samp(0);
		`CHK(dac_code, CODE_MID)
		// Excitation calibration walk.
		wr(A_EXC_CMD, 32'h1);
		rd(A_EXC_CMD);
		`CHK(h.rdata[0], 1'h1)
		wr(A_EXC_CMD, 32'h2);
		repeat (2) @(posedge core_clk);
		`CHK(exc_step_code, 6'h0)
		wr(A_METER, 32'd4100);
		wr(A_EXC_CMD, 32'h4);
		repeat (200) @(posedge core_clk);
		rd(A_EXC_MIN);
		`CHK(h.rdata, 32'd4100)
		wr(A_EXC_CMD, 32'h3);
		repeat (2) @(posedge core_clk);
		`CHK(exc_step_code, STEP_CODE_MAX)
		wr(A_METER, 32'd11000);
		wr(A_EXC_CMD, 32'h5);
		repeat (200) @(posedge core_clk);
		rd(A_STEP);
		`CHK(h.rdata, 32'(6900 * 256 / 63))
		wr(A_EXC_CMD, 32'h6);
		samp(0);
		rd(A_EXC_CMD);
		`CHK(h.rdata[1], 1'h1)
		wr(A_EXC_CMD, 32'h7);
		give_verdict();
	end
endmodule
